// ===== adcoc_defines.vh
// Purpose: constants of the converter output and clock control block
// Assumes: 7-bit register address space reached over the three-wire serial port
// Notes: definitions only
`ifndef ADCOC_DEFINES_VH
`define ADCOC_DEFINES_VH

`define ADCOC_ADDR_PD 7'h02
`define ADCOC_ADDR_TIMING 7'h03
`define ADCOC_ADDR_IMP_A 7'h04
`define ADCOC_ADDR_IMP_B 7'h05
`define ADCOC_ADDR_DIVFMT 7'h06
`define ADCOC_ADDR_RSVD 7'h07
`define ADCOC_ADDR_CMODE 7'h08
`define ADCOC_ADDR_SWRST 7'h0A

`define ADCOC_RST_PD 4'h0
`define ADCOC_RST_TIMING 8'h6D
`define ADCOC_RST_IMP 6'h00
`define ADCOC_RST_DIVFMT 8'h00
`define ADCOC_RST_CMODE 8'h00
`define ADCOC_SWRST_CODE 8'h5A
`define ADCOC_STATUS_BYTE 8'h15

`define ADCOC_PD_STATE_LSB 2
`define ADCOC_PD_RANGE_OFF 1
`define ADCOC_PD_CLK_OFF 0
`define ADCOC_TM_SKIP 7
`define ADCOC_TM_HALF 6
`define ADCOC_TM_CLK_LSB 3
`define ADCOC_TM_DATA_LSB 0
`define ADCOC_IMP_CLK_LSB 3
`define ADCOC_IMP_DATA_LSB 0
`define ADCOC_DF_PATTERN 7
`define ADCOC_DF_TEST 6
`define ADCOC_DF_FMT_LSB 4
`define ADCOC_DF_TERM 3
`define ADCOC_DF_SYNC 2
`define ADCOC_DF_DIV_LSB 0

`define ADCOC_FMT_OFFSET 2'h1
`define ADCOC_FMT_GRAY 2'h2
`define ADCOC_DIV_2 2'h1
`define ADCOC_DIV_4 2'h2

`define ADCOC_LATENCY 9
`define ADCOC_SYNC_EDGE 2'h2
`define ADCOC_HALF_STEPS 5'h08
`define ADCOC_CLK_LEAD 5'h02
`define ADCOC_PAT_HI 8'h55
`define ADCOC_PAT_LO 8'hAA

`endif

// ===== adcoc_fifo.v
// Purpose: sample buffer between the latency pipeline and the output stage
// Assumes: single clock, synchronous flags
// Notes: honest full and empty; drain side may stall
`timescale 1ns/1ps
`default_nettype none
module adcoc_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output reg [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ff] <= in_data_i;
    end
  end

  always @* begin
    out_data_o = mem[rd_ff];
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== adcoc_top.v
// Purpose: register file, clock divider, test data, formatting and output drivers
// Assumes: all inputs synchronous to clk_i; serial clock far slower than clk_i
// Notes: sub-cycle timing trims leave as codes and step counts for the analog delay line
`timescale 1ns/1ps
`default_nettype none
`include "adcoc_defines.vh"
module adcoc_top #(
  parameter LATENCY = `ADCOC_LATENCY,
  parameter FIFO_DEPTH = 16
) (
  input wire clk_i,
  input wire nrst_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire sdio_i,
  output reg sdio_o,
  output reg sdio_oe_o,
  input wire sync_i,
  input wire powerdown_i,
  input wire single_bus_select_i,
  input wire [7:0] sample_a_i,
  input wire [7:0] sample_b_i,
  input wire range_a_i,
  input wire range_b_i,
  input wire out_ready_i,
  output wire sample_tick_o,
  output reg [7:0] data_a_o,
  output wire data_a_oe_o,
  output reg [7:0] data_b_o,
  output wire data_b_oe_o,
  output reg out_of_range_flag_o,
  output wire out_of_range_flag_oe_o,
  output reg forwarded_output_clock_o,
  output wire forwarded_output_clock_oe_o,
  output wire aligner_skip_o,
  output wire [4:0] data_delay_steps_o,
  output wire [4:0] fwd_clock_delay_steps_o,
  output wire [4:0] data_impedance_sel_a_o,
  output wire [4:0] fwd_clock_impedance_sel_a_o,
  output wire [4:0] data_impedance_sel_b_o,
  output wire [4:0] fwd_clock_impedance_sel_b_o,
  output wire clock_term_o,
  output wire [7:0] common_level_ctrl_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SHIFT = 2'd1;
  localparam ST_DONE = 2'd2;
  localparam W = 17;

  // signed step count in sixteenths of a period; 100 never arrives
  function [4:0] delay_steps;
    input [2:0] code;
    begin
      delay_steps = code[2] ? (5'h00 - {3'b000, code[1:0]}) : {3'b000, code[1:0]};
    end
  endfunction

  // one-hot leg select: 50, 75, 100, 150, 300 ohm
  function [4:0] imp_sel;
    input [2:0] code;
    begin
      if (code[2]) begin
        imp_sel = 5'h10;
      end else begin
        imp_sel = 5'h01 << code[1:0];
      end
    end
  endfunction

  function [7:0] fmt;
    input [7:0] ob;
    input [1:0] mode;
    begin
      if (mode == `ADCOC_FMT_OFFSET) begin
        fmt = ob;
      end else if (mode == `ADCOC_FMT_GRAY) begin
        fmt = ob ^ {1'b0, ob[7:1]};
      end else begin
        fmt = {~ob[7], ob[6:0]};
      end
    end
  endfunction

  // control registers
  reg [3:0] pd_ff;
  reg [7:0] timing_ff;
  reg [5:0] imp_a_ff;
  reg [5:0] imp_b_ff;
  reg [7:0] divfmt_ff;
  reg [7:0] cmode_ff;

  // serial port
  reg [1:0] sp_state_ff;
  reg [4:0] bit_cnt_ff;
  reg [15:0] shift_ff;
  reg [7:0] rd_shift_ff;
  reg sclk_prev_ff;
  reg is_read_ff;
  wire sclk_rise;
  wire sclk_fall;
  reg [7:0] rd_val;

  assign sclk_rise = sclk_i & ~sclk_prev_ff;
  assign sclk_fall = ~sclk_i & sclk_prev_ff;

  always @* begin
    rd_val = 8'h00;
    if (shift_ff[6:0] == `ADCOC_ADDR_PD) begin
      rd_val = {4'h0, pd_ff};
    end else if (shift_ff[6:0] == `ADCOC_ADDR_TIMING) begin
      rd_val = timing_ff;
    end else if (shift_ff[6:0] == `ADCOC_ADDR_IMP_A) begin
      rd_val = {2'b00, imp_a_ff};
    end else if (shift_ff[6:0] == `ADCOC_ADDR_IMP_B) begin
      rd_val = {2'b00, imp_b_ff};
    end else if (shift_ff[6:0] == `ADCOC_ADDR_DIVFMT) begin
      rd_val = divfmt_ff;
    end else if (shift_ff[6:0] == `ADCOC_ADDR_CMODE) begin
      rd_val = cmode_ff;
    end else if (shift_ff[6:0] == `ADCOC_ADDR_SWRST) begin
      rd_val = `ADCOC_STATUS_BYTE;
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp_state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
      rd_shift_ff <= 8'h00;
      sclk_prev_ff <= 1'b0;
      is_read_ff <= 1'b0;
      sdio_o <= 1'b0;
      sdio_oe_o <= 1'b0;
      pd_ff <= `ADCOC_RST_PD;
      timing_ff <= `ADCOC_RST_TIMING;
      imp_a_ff <= `ADCOC_RST_IMP;
      imp_b_ff <= `ADCOC_RST_IMP;
      divfmt_ff <= `ADCOC_RST_DIVFMT;
      cmode_ff <= `ADCOC_RST_CMODE;
    end else begin
      sclk_prev_ff <= sclk_i;
      if (cs_n_i) begin
        sp_state_ff <= ST_IDLE;
        bit_cnt_ff <= 5'h00;
        sdio_oe_o <= 1'b0;
      end else begin
        case (sp_state_ff)
          ST_IDLE: begin
            sp_state_ff <= ST_SHIFT;
            bit_cnt_ff <= 5'h00;
          end
          ST_SHIFT: begin
            if (sclk_rise) begin
              shift_ff <= {shift_ff[14:0], sdio_i};
              bit_cnt_ff <= bit_cnt_ff + 5'h01;
              if (bit_cnt_ff == 5'h00) begin
                is_read_ff <= sdio_i;
              end
              if (bit_cnt_ff == 5'h0F) begin
                sp_state_ff <= ST_DONE;
                if (!is_read_ff) begin
                  if (shift_ff[13:7] == `ADCOC_ADDR_PD) begin
                    pd_ff <= {shift_ff[2:0], sdio_i};
                  end else if (shift_ff[13:7] == `ADCOC_ADDR_TIMING) begin
                    timing_ff <= {shift_ff[6:0], sdio_i};
                  end else if (shift_ff[13:7] == `ADCOC_ADDR_IMP_A) begin
                    imp_a_ff <= {shift_ff[4:0], sdio_i};
                  end else if (shift_ff[13:7] == `ADCOC_ADDR_IMP_B) begin
                    imp_b_ff <= {shift_ff[4:0], sdio_i};
                  end else if (shift_ff[13:7] == `ADCOC_ADDR_DIVFMT) begin
                    divfmt_ff <= {shift_ff[6:0], sdio_i};
                  end else if (shift_ff[13:7] == `ADCOC_ADDR_CMODE) begin
                    cmode_ff <= {shift_ff[6:0], sdio_i};
                  end else if (shift_ff[13:7] == `ADCOC_ADDR_SWRST &&
                               {shift_ff[6:0], sdio_i} == `ADCOC_SWRST_CODE) begin
                    pd_ff <= `ADCOC_RST_PD;
                    timing_ff <= `ADCOC_RST_TIMING;
                    imp_a_ff <= `ADCOC_RST_IMP;
                    imp_b_ff <= `ADCOC_RST_IMP;
                    divfmt_ff <= `ADCOC_RST_DIVFMT;
                    cmode_ff <= `ADCOC_RST_CMODE;
                  end
                end
              end
            end
            if (sclk_fall && is_read_ff && bit_cnt_ff == 5'h08 && !sdio_oe_o) begin
              sdio_oe_o <= 1'b1;
              sdio_o <= rd_val[7];
              rd_shift_ff <= {rd_val[6:0], 1'b0};
            end else if (sclk_fall && sdio_oe_o) begin
              sdio_o <= rd_shift_ff[7];
              rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
            end
          end
          default: begin
            if (sclk_fall) begin
              sdio_oe_o <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // clock divider with synchronisation
  reg [1:0] div_ff;
  reg [1:0] nxt_div;
  reg sync_prev_ff;
  reg [1:0] sync_cnt_ff;
  reg tick_ff;
  wire [1:0] div_sel;
  wire sync_act;
  wire div_clk_now;
  wire div_clk_nxt;

  assign div_sel = divfmt_ff[`ADCOC_DF_DIV_LSB+1:`ADCOC_DF_DIV_LSB];
  assign sync_act = (sync_cnt_ff == `ADCOC_SYNC_EDGE);
  assign div_clk_now = (div_sel == `ADCOC_DIV_4) ? div_ff[1] : div_ff[0];
  assign div_clk_nxt = (div_sel == `ADCOC_DIV_4) ? nxt_div[1] : nxt_div[0];

  always @* begin
    nxt_div = div_ff + 2'd1;
    if (div_sel == `ADCOC_DIV_2) begin
      nxt_div = {1'b0, ~div_ff[0]};
    end
    if (sync_act) begin
      if (divfmt_ff[`ADCOC_DF_SYNC]) begin
        nxt_div = 2'd0;
      end else begin
        nxt_div = div_ff;
      end
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_ff <= 2'd0;
      sync_prev_ff <= 1'b0;
      sync_cnt_ff <= 2'd0;
      tick_ff <= 1'b0;
    end else begin
      sync_prev_ff <= sync_i;
      if (sync_i & ~sync_prev_ff) begin
        sync_cnt_ff <= 2'd1;
      end else if (sync_cnt_ff != 2'd0) begin
        sync_cnt_ff <= (sync_act) ? 2'd0 : sync_cnt_ff + 2'd1;
      end
      div_ff <= nxt_div;
      if (div_sel == `ADCOC_DIV_2 || div_sel == `ADCOC_DIV_4) begin
        tick_ff <= ~div_clk_now & div_clk_nxt;
      end else begin
        tick_ff <= 1'b1;
      end
    end
  end
  assign sample_tick_o = tick_ff;

  // sample capture, test data and latency pipeline
  reg [7:0] ramp_ff;
  reg alt_ff;
  reg [W-1:0] pipe_ff [0:LATENCY-1];
  reg [LATENCY-1:0] pipe_vld_ff;
  reg [W-1:0] cap;
  wire [1:0] fmt_sel;
  wire fifo_in_ready;
  wire advance;

  assign fmt_sel = divfmt_ff[`ADCOC_DF_FMT_LSB+1:`ADCOC_DF_FMT_LSB];
  assign advance = tick_ff & (fifo_in_ready | ~pipe_vld_ff[LATENCY-1]);

  always @* begin
    cap = {range_a_i | range_b_i, fmt(sample_a_i, fmt_sel), fmt(sample_b_i, fmt_sel)};
    if (divfmt_ff[`ADCOC_DF_TEST]) begin
      if (divfmt_ff[`ADCOC_DF_PATTERN]) begin
        cap = alt_ff ? {1'b0, `ADCOC_PAT_LO, `ADCOC_PAT_LO} :
                       {1'b1, `ADCOC_PAT_HI, `ADCOC_PAT_HI};
      end else begin
        cap = {1'b0, fmt(ramp_ff, fmt_sel), fmt(ramp_ff, fmt_sel)};
      end
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ramp_ff <= 8'h00;
      alt_ff <= 1'b0;
      pipe_vld_ff <= {LATENCY{1'b0}};
    end else if (advance) begin
      ramp_ff <= ramp_ff + 8'h01;
      alt_ff <= ~alt_ff;
      pipe_vld_ff <= {pipe_vld_ff[LATENCY-2:0], 1'b1};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LATENCY; gi = gi + 1) begin : g_pipe
      always @(posedge clk_i) begin
        if (advance) begin
          if (gi == 0) begin
            pipe_ff[gi] <= cap;
          end else begin
            pipe_ff[gi] <= pipe_ff[(gi == 0) ? 0 : gi-1];
          end
        end
      end
    end
  endgenerate

  wire [W-1:0] fifo_out;
  wire fifo_out_valid;
  reg mux_phase_ff;
  reg [7:0] held_b_ff;
  wire pop;
  wire [1:0] pd_state;

  adcoc_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_data_i(pipe_ff[LATENCY-1]),
    .in_valid_i(advance & pipe_vld_ff[LATENCY-1]),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop)
  );

  // output stage: forwarded clock is high in each cycle that shows a new word or the held channel b
  assign pop = fifo_out_valid & out_ready_i & ~mux_phase_ff;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_a_o <= 8'h00;
      data_b_o <= 8'h00;
      out_of_range_flag_o <= 1'b0;
      forwarded_output_clock_o <= 1'b0;
      mux_phase_ff <= 1'b0;
      held_b_ff <= 8'h00;
    end else begin
      forwarded_output_clock_o <= pop | mux_phase_ff;
      mux_phase_ff <= 1'b0;
      if (pop) begin
        data_a_o <= fifo_out[15:8];
        data_b_o <= fifo_out[7:0];
        held_b_ff <= fifo_out[7:0];
        out_of_range_flag_o <= fifo_out[16];
        mux_phase_ff <= single_bus_select_i;
      end else if (mux_phase_ff) begin
        data_a_o <= held_b_ff;
      end
      if (powerdown_i && pd_state[0]) begin
        data_a_o <= {8{pd_state[1]}};
        data_b_o <= {8{pd_state[1]}};
      end
    end
  end

  // drivers and trims
  assign pd_state = pd_ff[`ADCOC_PD_STATE_LSB+1:`ADCOC_PD_STATE_LSB];
  assign data_a_oe_o = ~powerdown_i | pd_state[0];
  assign data_b_oe_o = (~powerdown_i & ~single_bus_select_i) | (powerdown_i & pd_state[0]);
  assign out_of_range_flag_oe_o = ~pd_ff[`ADCOC_PD_RANGE_OFF];
  assign forwarded_output_clock_oe_o = ~pd_ff[`ADCOC_PD_CLK_OFF];

  wire half_on;
  wire [4:0] half_add;
  assign half_on = timing_ff[`ADCOC_TM_HALF] & ~single_bus_select_i;
  assign half_add = half_on ? `ADCOC_HALF_STEPS : 5'h00;
  assign aligner_skip_o = timing_ff[`ADCOC_TM_SKIP];
  assign data_delay_steps_o =
    delay_steps(timing_ff[`ADCOC_TM_DATA_LSB+2:`ADCOC_TM_DATA_LSB]) + half_add;
  assign fwd_clock_delay_steps_o =
    delay_steps(timing_ff[`ADCOC_TM_CLK_LSB+2:`ADCOC_TM_CLK_LSB]) + half_add -
    `ADCOC_CLK_LEAD;
  assign data_impedance_sel_a_o = imp_sel(imp_a_ff[`ADCOC_IMP_DATA_LSB+2:`ADCOC_IMP_DATA_LSB]);
  assign fwd_clock_impedance_sel_a_o = imp_sel(imp_a_ff[`ADCOC_IMP_CLK_LSB+2:`ADCOC_IMP_CLK_LSB]);
  assign data_impedance_sel_b_o = imp_sel(imp_b_ff[`ADCOC_IMP_DATA_LSB+2:`ADCOC_IMP_DATA_LSB]);
  assign fwd_clock_impedance_sel_b_o = imp_sel(imp_b_ff[`ADCOC_IMP_CLK_LSB+2:`ADCOC_IMP_CLK_LSB]);
  assign clock_term_o = divfmt_ff[`ADCOC_DF_TERM];
  assign common_level_ctrl_o = cmode_ff;
endmodule
`default_nettype wire

// ===== adcoc_chk.sv
// Purpose: port-level checks of the output and clock control block
// Assumes: single clock domain, asynchronous active-low reset
// Notes: attached by bind after the module
`timescale 1ns/1ps
`default_nettype none
module adcoc_chk #(
  parameter LATENCY = 9,
  parameter FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic powerdown_i,
  input wire logic single_bus_select_i,
  input wire logic sdio_oe_o,
  input wire logic [7:0] data_a_o,
  input wire logic [7:0] data_b_o,
  input wire logic data_a_oe_o,
  input wire logic data_b_oe_o,
  input wire logic out_of_range_flag_oe_o,
  input wire logic forwarded_output_clock_o,
  input wire logic forwarded_output_clock_oe_o,
  input wire logic [4:0] data_delay_steps_o,
  input wire logic [4:0] data_impedance_sel_a_o,
  input wire logic [4:0] fwd_clock_impedance_sel_b_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  property p_pd_oe;
    !powerdown_i |-> data_a_oe_o && (data_b_oe_o == !single_bus_select_i);
  endproperty
  a_pd_oe: assert property (p_pd_oe) else $error("data pins released while powered");
  property p_pd_level;
    powerdown_i && $past(powerdown_i) && data_a_oe_o |->
      (data_a_o == 8'h00 || data_a_o == 8'hFF) && data_b_o == data_a_o && data_b_oe_o;
  endproperty
  a_pd_level: assert property (p_pd_level) else $error("powered-down level wrong");
  property p_flag_oe;
    $changed(out_of_range_flag_oe_o) |-> !$past(cs_n_i);
  endproperty
  a_flag_oe: assert property (p_flag_oe) else $error("flag enable moved outside a frame");
  property p_clk_oe;
    $changed(forwarded_output_clock_oe_o) |-> !$past(cs_n_i);
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock enable moved outside a frame");
  property p_half;
    single_bus_select_i && $past(single_bus_select_i) |->
      data_delay_steps_o inside {[5'h00:5'h03], [5'h1D:5'h1F]};
  endproperty
  a_half: assert property (p_half) else $error("half delay active in single bus");
  property p_steps;
    data_delay_steps_o inside {[5'h00:5'h0B], [5'h1D:5'h1F]};
  endproperty
  a_steps: assert property (p_steps) else $error("data delay steps out of range");
  property p_imp;
    $onehot(data_impedance_sel_a_o) && $onehot(fwd_clock_impedance_sel_b_o);
  endproperty
  a_imp: assert property (p_imp) else $error("impedance select not one-hot");
  property p_data_fwd;
    !powerdown_i && $past(powerdown_i) == 1'b0 && $changed(data_a_o) |->
      forwarded_output_clock_o;
  endproperty
  a_data_fwd: assert property (p_data_fwd) else $error("data moved without clock");
  property p_sdio;
    sdio_oe_o |-> !$past(cs_n_i);
  endproperty
  a_sdio: assert property (p_sdio) else $error("serial data driven while deselected");
  c_word: cover property (forwarded_output_clock_o);
  c_pd: cover property (powerdown_i && data_a_oe_o);
  c_read: cover property (sdio_oe_o);
endmodule
bind adcoc_top adcoc_chk #(.LATENCY(LATENCY), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (.*);
`default_nettype wire

// ===== adcoc_rx_model.sv
// Purpose: receiving logic that paces ready and counts forwarded words
// Assumes: ready may stall or pace the output stage
// Notes: counts words seen with the forwarded clock
`timescale 1ns/1ps
`default_nettype none
module adcoc_rx_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic slow_i,
  input wire logic stall_i,
  input wire logic fwd_clock_i,
  output logic ready_o,
  output logic [15:0] words_o
);
  logic [1:0] phase_ff;
  // slow mode accepts one cycle in four
  assign ready_o = !stall_i && (!slow_i || phase_ff == 2'h3);
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_ff <= 2'h0;
      words_o <= 16'h0000;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      if (fwd_clock_i) begin
        words_o <= words_o + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== adcoc_top_bench.sv
// Purpose: self-checking bench of the output and clock control block
// Assumes: serial port driven as the host, receiver modelled apart
// Notes: expectations come from the register encodings
`timescale 1ns/1ps
`default_nettype none
module adcoc_top_bench;
  logic clk_i, nrst_i, cs_n_i, sclk_i, sync_i, powerdown_i, single_bus_select_i;
  logic range_a_i, range_b_i, tb_d, slow, stall;
  logic [7:0] sample_a_i, sample_b_i, rd, a, b, a2, b2;
  logic fl, f2;
  logic [11:0] m, m0;
  wire sdio_i, sdio_o, sdio_oe_o, out_ready_i, sample_tick_o, data_a_oe_o, data_b_oe_o;
  wire out_of_range_flag_o, out_of_range_flag_oe_o, forwarded_output_clock_o;
  wire forwarded_output_clock_oe_o, aligner_skip_o, clock_term_o;
  wire [7:0] data_a_o, data_b_o, common_level_ctrl_o;
  wire [4:0] data_delay_steps_o, fwd_clock_delay_steps_o, data_impedance_sel_a_o;
  wire [4:0] fwd_clock_impedance_sel_a_o, data_impedance_sel_b_o, fwd_clock_impedance_sel_b_o;
  wire [15:0] words;
  int n_mismatch, comparisons, n;
  assign sdio_i = sdio_oe_o ? sdio_o : tb_d;
  adcoc_top i_dut (.*);
  adcoc_rx_model i_rx (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .stall_i(stall),
    .fwd_clock_i(forwarded_output_clock_o), .ready_o(out_ready_i), .words_o(words));
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // host releases data during the read half and toggles its own level
  task automatic frame(input logic rw, input logic [6:0] ad, input logic [7:0] d);
    logic [15:0] sh;
    sh = {rw, ad, d};
    cs_n_i = 0;
    tick(2);
    for (int i = 15; i >= 0; i--) begin
      tb_d = (rw && i < 8) ? ~tb_d : sh[i];
      sclk_i = 0;
      tick(4);
      if (i < 8) rd[i] = sdio_i;
      sclk_i = 1;
      tick(4);
    end
    cs_n_i = 1;
    tick(3);
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    frame(1'b0, ad, d);
  endtask
  task automatic rdchk(input logic [6:0] ad, input logic [7:0] exp);
    frame(1'b1, ad, 8'h00);
    chk(rd, exp);
  endtask
  task automatic grab(output logic [7:0] ga, output logic [7:0] gb, output logic gf);
    int w;
    w = 0;
    while (forwarded_output_clock_o !== 1'b1 && w < 100) begin
      tick(1);
      w++;
    end
    chk(forwarded_output_clock_o, 1'b1);
    ga = data_a_o;
    gb = data_b_o;
    gf = out_of_range_flag_o;
    tick(1);
  endtask
  function automatic logic [4:0] oh(input int c);
    return c[2] ? 5'h10 : 5'h01 << c;
  endfunction
  task automatic t_regs;
    rdchk(7'h02, 8'h00);
    rdchk(7'h03, 8'h6D);
    rdchk(7'h06, 8'h00);
    rdchk(7'h0A, 8'h15);
    rdchk(7'h7F, 8'h00);
    rdchk(7'h07, 8'h00);
    wr(7'h02, 8'hFF);
    rdchk(7'h02, 8'h0F);
    wr(7'h03, 8'h12);
    wr(7'h08, 8'hA5);
    wr(7'h0A, 8'h33);
    rdchk(7'h03, 8'h12);
    chk(common_level_ctrl_o, 8'hA5);
    wr(7'h0A, 8'h5A);
    rdchk(7'h03, 8'h6D);
    rdchk(7'h02, 8'h00);
    chk(common_level_ctrl_o, 8'h00);
  endtask
  task automatic t_drivers;
    for (int c = 0; c < 4; c++) begin
      wr(7'h02, 8'(c << 2) | 8'h01);
      powerdown_i = 1;
      tick(3);
      chk(data_a_oe_o, c[0]);
      if (c[0]) chk({data_a_o, data_b_o}, {16{c[1]}});
      chk({forwarded_output_clock_oe_o, out_of_range_flag_oe_o}, 2'h1);
      powerdown_i = 0;
    end
    wr(7'h02, 8'h02);
    chk({forwarded_output_clock_oe_o, out_of_range_flag_oe_o}, 2'h2);
    wr(7'h02, 8'h00);
  endtask
  task automatic t_timing;
    logic [4:0] s;
    for (int c = 0; c < 8; c++) begin
      if (c != 4) begin
        s = c[2] ? 5'(-(c & 3)) : 5'(c);
        wr(7'h03, {2'h3, 3'(c), 3'(c)});
        chk({aligner_skip_o, data_delay_steps_o, fwd_clock_delay_steps_o},
          {1'b1, s + 5'h08, s + 5'h06});
        single_bus_select_i = 1;
        tick(2);
        chk({data_delay_steps_o, fwd_clock_delay_steps_o}, {s, s - 5'h02});
        single_bus_select_i = 0;
      end
    end
  endtask
  task automatic t_imp;
    for (int c = 0; c < 8; c++) begin
      wr(7'h04, {2'h0, 3'(7 - c), 3'(c)});
      wr(7'h05, {2'h0, 3'(c), 3'(7 - c)});
      chk({data_impedance_sel_a_o, fwd_clock_impedance_sel_a_o, data_impedance_sel_b_o,
        fwd_clock_impedance_sel_b_o}, {oh(c), oh(7 - c), oh(7 - c), oh(c)});
    end
  endtask
  task automatic t_format;
    logic [15:0] e;
    sample_a_i = 8'hC3;
    sample_b_i = 8'h15;
    range_a_i = 1;
    slow = 1;
    for (int f = 0; f < 4; f++) begin
      wr(7'h06, 8'(f << 4));
      // a full buffer of old-format words drains at one per four cycles
      tick(140);
      grab(a, b, fl);
      e = f == 1 ? 16'hC315 : f == 2 ? 16'hA21F : 16'h4395;
      chk({a, b, fl}, {e, 1'b1});
    end
    single_bus_select_i = 1;
    tick(8);
    // let a phase already showing pass so the first grab lands on channel a
    repeat (2) if (forwarded_output_clock_o) tick(1);
    grab(a, b, fl);
    grab(a2, b2, f2);
    chk({a, a2, data_b_oe_o}, {8'h43, 8'h95, 1'b0});
    single_bus_select_i = 0;
    slow = 0;
    range_a_i = 0;
  endtask
  task automatic t_pattern;
    wr(7'h06, 8'hC0);
    tick(40);
    grab(a, b, fl);
    grab(a2, b2, f2);
    chk({a ^ a2, a ^ b, fl ^ f2, fl, a == 8'h55 || a == 8'hAA},
      {8'hFF, 8'h00, 1'b1, a == 8'h55, 1'b1});
    wr(7'h06, 8'h50);
    tick(40);
    grab(a, b, fl);
    grab(a2, b2, f2);
    chk({a2 - a, b2 - b}, 16'h0101);
    stall = 1;
    tick(4);
    n = words;
    tick(60);
    chk(words, n);
    stall = 0;
    grab(a, b, fl);
    grab(a2, b2, f2);
    chk(a2 - a, 8'h01);
  endtask
  task automatic t_div;
    for (int d = 0; d < 4; d++) begin
      wr(7'h06, {4'h0, d[0], 3'(d)});
      tick(8);
      chk(clock_term_o, d[0]);
      n = 0;
      repeat (40) begin
        n += sample_tick_o;
        tick(1);
      end
      chk(n, d == 1 ? 20 : d == 2 ? 10 : 40);
    end
  endtask
  task automatic mask(input logic [7:0] cfg, input int p, output logic [11:0] mk);
    wr(7'h06, cfg);
    tick(p);
    sync_i = 1;
    for (int i = 0; i < 12; i++) begin
      tick(1);
      mk[i] = sample_tick_o;
    end
    sync_i = 0;
    tick(2);
  endtask
  task automatic t_sync;
    int gap, mx;
    gap = 0;
    mx = 0;
    mask(8'h01, 0, m);
    for (int i = 0; i < 12; i++) begin
      gap = m[i] ? 0 : gap + 1;
      if (gap > mx) mx = gap;
    end
    chk(mx, 2);
    mask(8'h06, 0, m0);
    for (int p = 1; p < 4; p++) begin
      mask(8'h06, p, m);
      chk(m[11:4], m0[11:4]);
    end
    mask(8'h05, 0, m);
    chk({m0[11:5] & ~m[10:4], 4'($countones(m0[11:4]))}, {7'h00, 4'h2});
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    {nrst_i, sync_i, powerdown_i, single_bus_select_i, range_a_i, range_b_i} = 6'h00;
    {cs_n_i, sclk_i, tb_d, slow, stall} = 5'h18;
    sample_a_i = 8'h00;
    sample_b_i = 8'h00;
    tick(3);
    nrst_i = 1;
    tick(1);
    t_regs;
    t_drivers;
    t_timing;
    t_imp;
    t_format;
    t_pattern;
    t_div;
    t_sync;
    conclude;
  end
  initial begin
    #600000;
    n_mismatch++;
    conclude;
  end
endmodule
`default_nettype wire
